// ### bench/loopback_sva.sv
`timescale 1ns/1ps
module loopback_sva #(
   parameter ADDR_W = 12
) (
   input wire sys_clk_in,
   input wire rst_in,
   input wire clk_en_in,
   input wire rx_good_frame_in,
   input wire rx_bad_frame_in,
   input wire [7:0] tx_data_out,
   input wire tx_data_valid_out,
   input wire tx_ack_in,
   input wire tx_collision_in,
   input wire tx_retransmit_in,
   input wire rx_overflow_out,
   input wire tx_overflow_out,
   input wire [3:0] rx_fifo_status_out,
   input wire [3:0] tx_fifo_status_out
);
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (rst_in);

   sequence s_offer;
      $rose(tx_data_valid_out) && !tx_ack_in && !tx_collision_in && !tx_retransmit_in;
   endsequence
   sequence s_taken;
      tx_data_valid_out && tx_ack_in && clk_en_in;
   endsequence
   sequence s_abort;
      tx_data_valid_out && tx_retransmit_in && clk_en_in;
   endsequence

   property p_reset_quiet;
      $fell(rst_in) |-> !tx_data_valid_out && !rx_overflow_out && !tx_overflow_out
         && rx_fifo_status_out == 4'h0 && tx_fifo_status_out == 4'h0;
   endproperty
   property p_rx_ovf_once;
      rx_overflow_out && clk_en_in |=> !rx_overflow_out;
   endproperty
   property p_rx_ovf_cause;
      $rose(rx_overflow_out) |-> $past((rx_good_frame_in || rx_bad_frame_in) && clk_en_in);
   endproperty
   property p_tx_ovf_once;
      tx_overflow_out && clk_en_in |=> !tx_overflow_out;
   endproperty
   property p_offer_hold;
      s_offer |=> tx_data_valid_out && $stable(tx_data_out);
   endproperty
   property p_ack_next;
      s_taken |=> tx_data_valid_out;
   endproperty
   property p_gap;
      $fell(tx_data_valid_out) |-> $stable(tx_data_out);
   endproperty
   property p_retx_restart;
      s_abort |-> ##[1:400] s_taken;
   endproperty

   a_reset_quiet: assert property (p_reset_quiet)
      else $error("outputs not idle after reset");
   a_rx_ovf_once: assert property (p_rx_ovf_once)
      else $error("rx overflow longer than one cycle");
   a_rx_ovf_cause: assert property (p_rx_ovf_cause)
      else $error("rx overflow without frame end");
   a_tx_ovf_once: assert property (p_tx_ovf_once)
      else $error("tx overflow longer than one cycle");
   a_offer_hold: assert property (p_offer_hold)
      else $error("first byte not held");
   a_ack_next: assert property (p_ack_next)
      else $error("frame stopped after acknowledge");
   a_gap: assert property (p_gap)
      else $error("last byte changed at frame end");
   a_retx_restart: assert property (p_retx_restart)
      else $error("frame not offered again after retransmit");
endmodule

bind ethernet_client_loopback_fifo loopback_sva #(.ADDR_W(ADDR_W)) u_sva (
   .sys_clk_in(sys_clk_in),
   .rst_in(rst_in),
   .clk_en_in(clk_en_in),
   .rx_good_frame_in(rx_good_frame_in),
   .rx_bad_frame_in(rx_bad_frame_in),
   .tx_data_out(tx_data_out),
   .tx_data_valid_out(tx_data_valid_out),
   .tx_ack_in(tx_ack_in),
   .tx_collision_in(tx_collision_in),
   .tx_retransmit_in(tx_retransmit_in),
   .rx_overflow_out(rx_overflow_out),
   .tx_overflow_out(tx_overflow_out),
   .rx_fifo_status_out(rx_fifo_status_out),
   .tx_fifo_status_out(tx_fifo_status_out)
);

// ### bench/mac_tx_partner.sv
`timescale 1ns/1ps
module mac_tx_partner (
   input wire sys_clk_in,
   input wire rst_in,
   input wire clk_en_in,
   input wire tx_data_valid_in,
   input wire arm_in,
   input wire [1:0] mode_in,
   input wire [1:0] delay_in,
   output logic tx_ack_out,
   output logic tx_collision_out,
   output logic tx_retransmit_out
);
   logic [1:0] st_r;
   logic [1:0] cnt_r;
   logic [1:0] mode_r;

   // Mode 1 aborts the next offer with retransmit, mode 2 with collision alone
   always @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         st_r <= 2'h0;
         cnt_r <= 2'h0;
         mode_r <= 2'h0;
         tx_ack_out <= 1'b0;
         tx_collision_out <= 1'b0;
         tx_retransmit_out <= 1'b0;
      end
      else if (clk_en_in)
      begin
         tx_ack_out <= 1'b0;
         tx_collision_out <= 1'b0;
         tx_retransmit_out <= 1'b0;
         if (arm_in)
            mode_r <= mode_in;
         case (st_r)
            2'h0: if (tx_data_valid_in)
            begin
               cnt_r <= delay_in;
               st_r <= 2'h1;
            end
            2'h1: if (cnt_r != 2'h0)
               cnt_r <= cnt_r - 2'h1;
            else if (mode_r == 2'h0)
            begin
               tx_ack_out <= 1'b1;
               st_r <= 2'h2;
            end
            else
            begin
               tx_collision_out <= 1'b1;
               tx_retransmit_out <= (mode_r == 2'h1);
               mode_r <= 2'h0;
               st_r <= 2'h3;
            end
            2'h2: if (!tx_data_valid_in)
               st_r <= 2'h0;
            default: st_r <= 2'h0;
         endcase
      end
   end
endmodule

// ### bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic sys_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic clk_en_in = 1'b1;
   logic [7:0] rx_data_in = 8'h00;
   logic rx_data_valid_in = 1'b0;
   logic rx_good_frame_in = 1'b0;
   logic rx_bad_frame_in = 1'b0;
   logic arm_in = 1'b0;
   logic [1:0] mode_in = 2'h0;
   logic [1:0] delay_in = 2'h0;
   wire [7:0] tx_data_out;
   wire tx_data_valid_out;
   wire tx_ack_in;
   wire tx_collision_in;
   wire tx_retransmit_in;
   wire rx_overflow_out;
   wire tx_overflow_out;
   wire [3:0] rx_fifo_status_out;
   wire [3:0] tx_fifo_status_out;
   int mismatches = 0;
   int n_checks = 0;
   int n_ovf = 0;
   int got = 0;
   bit streaming = 0;
   logic [7:0] exp_q[$];
   int len_q[$];

   always #2 sys_clk_in = ~sys_clk_in;

   ethernet_client_loopback_fifo #(.ADDR_W(12)) u_dut (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .clk_en_in(clk_en_in),
      .rx_data_in(rx_data_in),
      .rx_data_valid_in(rx_data_valid_in),
      .rx_good_frame_in(rx_good_frame_in),
      .rx_bad_frame_in(rx_bad_frame_in),
      .tx_data_out(tx_data_out),
      .tx_data_valid_out(tx_data_valid_out),
      .tx_ack_in(tx_ack_in),
      .tx_collision_in(tx_collision_in),
      .tx_retransmit_in(tx_retransmit_in),
      .rx_overflow_out(rx_overflow_out),
      .tx_overflow_out(tx_overflow_out),
      .rx_fifo_status_out(rx_fifo_status_out),
      .tx_fifo_status_out(tx_fifo_status_out)
   );

   mac_tx_partner u_mac (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .clk_en_in(clk_en_in),
      .tx_data_valid_in(tx_data_valid_out),
      .arm_in(arm_in),
      .mode_in(mode_in),
      .delay_in(delay_in),
      .tx_ack_out(tx_ack_in),
      .tx_collision_out(tx_collision_in),
      .tx_retransmit_out(tx_retransmit_in)
   );

   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task close_out;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Receive client driver; notes the looped-back bytes it expects
   // ----------------------------------------------------------------
   task send_frame(input int len, input bit good, input bit keep);
      logic [7:0] b[$];
      int j;
      for (int i = 0; i < len; i++)
         b.push_back($urandom);
      for (int i = 0; i < len; i++)
      begin
         @(posedge sys_clk_in);
         rx_data_valid_in <= 1'b1;
         rx_data_in <= b[i];
         #1;
         if (len_q.size() == 0)
            check("tx_early", tx_data_valid_out, 1'b0);
         if (i == 600)
            check("rx_status", rx_fifo_status_out, 4'h2);
      end
      @(posedge sys_clk_in);
      rx_data_valid_in <= 1'b0;
      rx_data_in <= ~b[len-1];
      rx_good_frame_in <= good;
      rx_bad_frame_in <= !good;
      @(posedge sys_clk_in);
      rx_good_frame_in <= 1'b0;
      rx_bad_frame_in <= 1'b0;
      rx_data_in <= $urandom;
      if (good && keep)
      begin
         for (int i = 0; i < len; i++)
         begin
            j = (len < 12 || i >= 12) ? i : (i < 6 ? i + 6 : i - 6);
            exp_q.push_back(b[j]);
         end
         len_q.push_back(len);
      end
   endtask

   task arm(input logic [1:0] mode);
      @(posedge sys_clk_in);
      arm_in <= 1'b1;
      mode_in <= mode;
      @(posedge sys_clk_in);
      arm_in <= 1'b0;
   endtask

   task wait_drain;
      // Frames that are not noted still cross the loop; let them leave first
      repeat (300) @(posedge sys_clk_in);
      for (int k = 0; k < 5000 && (len_q.size() != 0 || streaming); k++)
         @(posedge sys_clk_in);
      repeat (8) @(posedge sys_clk_in);
      check("pending", len_q.size(), 0);
      check("tx_status", tx_fifo_status_out, 4'h0);
      check("rx_status", rx_fifo_status_out, 4'h0);
   endtask

   // ----------------------------------------------------------------
   // Transmit monitor: a byte counts at the ack edge and after it
   // ----------------------------------------------------------------
   always @(posedge sys_clk_in)
   begin
      if (!rst_in && clk_en_in)
      begin
         if (tx_data_valid_out && (streaming || tx_ack_in))
         begin
            streaming = 1;
            got++;
            check("tx_data", tx_data_out, exp_q.size() ? exp_q.pop_front() : 32'h0000_0100);
         end
         else if (!tx_data_valid_out && streaming)
         begin
            streaming = 0;
            check("tx_len", got, len_q.size() ? len_q.pop_front() : -1);
            got = 0;
         end
         if (rx_overflow_out)
            n_ovf++;
         check("tx_ovf", tx_overflow_out, 1'b0);
      end
   end

   initial
   begin
      repeat (60000) @(posedge sys_clk_in);
      mismatches++;
      close_out;
   end

   initial
   begin
      void'($urandom(77201));
      repeat (16) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      delay_in <= 2'h3;
      send_frame(60, 1, 1);
      send_frame(8, 1, 1);
      send_frame(12, 1, 1);
      send_frame(13, 0, 1);
      send_frame(40, 1, 1);
      wait_drain;
      for (int f = 0; f < 10; f++)
      begin
         delay_in <= $urandom;
         send_frame(12 + $urandom % 70, ($urandom % 4) != 0, 1);
      end
      wait_drain;
      arm(2'h1);
      send_frame(30, 1, 1);
      wait_drain;
      arm(2'h2);
      send_frame(30, 1, 0);
      wait_drain;
      send_frame(50, 1, 1);
      repeat (40) @(posedge sys_clk_in) clk_en_in <= ($urandom % 3) != 0;
      clk_en_in <= 1'b1;
      wait_drain;
      send_frame(4200, 1, 0);
      repeat (4) @(posedge sys_clk_in);
      check("rx_ovf", n_ovf, 1);
      send_frame(20, 1, 1);
      wait_drain;
      close_out;
   end
endmodule

// ### design/ethernet_client_loopback_fifo.v
`timescale 1ns/1ps
`include "loopback_consts.vh"

// ----------------------------------------------------------------------
// Small synchronous FIFO with valid/ready on both sides
// ----------------------------------------------------------------------
module loop_fifo #(
   parameter WIDTH = `LB_LOOP_W,
   parameter DEPTH = `LB_LOOP_DEPTH,
   parameter AW = `LB_LOOP_AW
) (
   input wire sys_clk_in,
   input wire rst_in,
   input wire clk_en_in,
   input wire in_valid_in,
   output wire in_ready_out,
   input wire [WIDTH-1:0] in_data_in,
   output wire out_valid_out,
   input wire out_ready_in,
   output wire [WIDTH-1:0] out_data_out
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_r;
   reg [AW-1:0] rd_r;
   reg [AW:0] cnt_r;
   wire push;
   wire pop;

   assign in_ready_out = (cnt_r != DEPTH);
   assign out_valid_out = (cnt_r != 0);
   assign out_data_out = mem[rd_r];
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;

   always @(posedge sys_clk_in)
   begin
      if (clk_en_in && push)
         mem[wr_r] <= in_data_in;
   end

   always @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         wr_r <= {AW{1'b0}};
         rd_r <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
      end
      else if (clk_en_in)
      begin
         if (push)
            wr_r <= wr_r + 1'b1;
         if (pop)
            rd_r <= rd_r + 1'b1;
         if (push && !pop)
            cnt_r <= cnt_r + 1'b1;
         else if (pop && !push)
            cnt_r <= cnt_r - 1'b1;
      end
   end
endmodule

// ----------------------------------------------------------------------
// Client loopback: receive buffer, loop FIFO, swap, transmit buffer
// ----------------------------------------------------------------------
module ethernet_client_loopback_fifo #(
   parameter ADDR_W = `LB_BUF_ADDR_W
) (
   input wire sys_clk_in,
   input wire rst_in,
   input wire clk_en_in,
   input wire [7:0] rx_data_in,
   input wire rx_data_valid_in,
   input wire rx_good_frame_in,
   input wire rx_bad_frame_in,
   output reg [7:0] tx_data_out,
   output reg tx_data_valid_out,
   input wire tx_ack_in,
   input wire tx_collision_in,
   input wire tx_retransmit_in,
   output reg rx_overflow_out,
   output reg tx_overflow_out,
   output wire [3:0] rx_fifo_status_out,
   output wire [3:0] tx_fifo_status_out
);
   localparam DEPTH = 1 << ADDR_W;
   localparam T_IDLE = 4'b0001;
   localparam T_WAIT = 4'b0010;
   localparam T_SEND = 4'b0100;
   localparam T_SKIP = 4'b1000;
   localparam S_COLL = 3'b001;
   localparam S_EMIT = 3'b010;
   localparam S_PASS = 3'b100;
   localparam [`LB_HDR_CNT_W-1:0] ADDR_LEN_C = `LB_ADDR_LEN;

   // ----------------------------------------------------------------------
   // Receive buffer
   // ----------------------------------------------------------------------
   reg [7:0] rx_mem [0:DEPTH-1];
   reg rx_sof_mem [0:DEPTH-1];
   reg rx_eof_mem [0:DEPTH-1];
   reg [ADDR_W-1:0] rx_wr_r;
   reg [ADDR_W-1:0] rx_start_r;
   reg [ADDR_W-1:0] rx_commit_r;
   reg [ADDR_W-1:0] rx_rd_r;
   reg rx_drop_r;
   reg rx_in_frame_r;
   reg [7:0] rx_ll_data_r;
   reg rx_ll_sof_n_r;
   reg rx_ll_eof_n_r;
   reg rx_ll_src_rdy_n_r;
   wire rx_full;
   wire rx_store;
   wire rx_out_free;
   wire [ADDR_W-1:0] rx_fill;
   wire loop_in_ready;

   assign rx_full = ((rx_wr_r + 1'b1) == rx_rd_r);
   assign rx_store = rx_data_valid_in && !rx_drop_r && !rx_full;
   assign rx_fill = rx_wr_r - rx_rd_r;
   assign rx_fifo_status_out = rx_fill[ADDR_W-1:`LB_STATUS_SHIFT];
   assign rx_out_free = rx_ll_src_rdy_n_r || loop_in_ready;

   always @(posedge sys_clk_in)
   begin
      if (clk_en_in)
      begin
         if (rx_store)
         begin
            rx_mem[rx_wr_r] <= rx_data_in;
            rx_sof_mem[rx_wr_r] <= !rx_in_frame_r;
            rx_eof_mem[rx_wr_r] <= 1'b0;
         end
         if (rx_good_frame_in && !rx_drop_r && (rx_wr_r != rx_start_r))
            rx_eof_mem[rx_wr_r - 1'b1] <= 1'b1;
      end
   end

   always @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         rx_wr_r <= {ADDR_W{1'b0}};
         rx_start_r <= {ADDR_W{1'b0}};
         rx_commit_r <= {ADDR_W{1'b0}};
         rx_drop_r <= 1'b0;
         rx_in_frame_r <= 1'b0;
         rx_overflow_out <= 1'b0;
      end
      else if (clk_en_in)
      begin
         rx_overflow_out <= 1'b0;
         if (rx_data_valid_in)
         begin
            rx_in_frame_r <= 1'b1;
            if (rx_drop_r || rx_full)
               rx_drop_r <= 1'b1;
            else
               rx_wr_r <= rx_wr_r + 1'b1;
         end
         if (rx_good_frame_in || rx_bad_frame_in)
         begin
            rx_in_frame_r <= 1'b0;
            rx_drop_r <= 1'b0;
            if (rx_drop_r)
            begin
               rx_wr_r <= rx_start_r;
               rx_overflow_out <= 1'b1;
            end
            else if (rx_bad_frame_in)
               rx_wr_r <= rx_start_r;
            else
            begin
               rx_commit_r <= rx_wr_r;
               rx_start_r <= rx_wr_r;
            end
         end
      end
   end

   // Only committed bytes are visible to the framed output side
   always @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         rx_rd_r <= {ADDR_W{1'b0}};
         rx_ll_data_r <= 8'h00;
         rx_ll_sof_n_r <= 1'b1;
         rx_ll_eof_n_r <= 1'b1;
         rx_ll_src_rdy_n_r <= 1'b1;
      end
      else if (clk_en_in && rx_out_free)
      begin
         if (rx_rd_r != rx_commit_r)
         begin
            rx_ll_data_r <= rx_mem[rx_rd_r];
            rx_ll_sof_n_r <= !rx_sof_mem[rx_rd_r];
            rx_ll_eof_n_r <= !rx_eof_mem[rx_rd_r];
            rx_ll_src_rdy_n_r <= 1'b0;
            rx_rd_r <= rx_rd_r + 1'b1;
         end
         else
            rx_ll_src_rdy_n_r <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // Loop FIFO feeding the address swap
   // ----------------------------------------------------------------------
   wire loop_out_valid;
   wire [`LB_LOOP_W-1:0] loop_out_data;
   wire sw_in_ready;

   loop_fifo #(
      .WIDTH(`LB_LOOP_W),
      .DEPTH(`LB_LOOP_DEPTH),
      .AW(`LB_LOOP_AW)
   ) u_loop_fifo (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .clk_en_in(clk_en_in),
      .in_valid_in(!rx_ll_src_rdy_n_r),
      .in_ready_out(loop_in_ready),
      .in_data_in({!rx_ll_sof_n_r, !rx_ll_eof_n_r, rx_ll_data_r}),
      .out_valid_out(loop_out_valid),
      .out_ready_in(sw_in_ready),
      .out_data_out(loop_out_data)
   );

   // ----------------------------------------------------------------------
   // Address swap: collect header, emit it swapped if 12 bytes long, then pass through
   // ----------------------------------------------------------------------
   reg [7:0] hdr_r [0:`LB_HDR_LEN-1];
   reg [2:0] sw_state_r;
   reg [`LB_HDR_CNT_W-1:0] hdr_cnt_r;
   reg [`LB_HDR_CNT_W-1:0] hdr_len_r;
   reg [`LB_HDR_CNT_W-1:0] emit_r;
   reg hdr_eof_r;
   reg [7:0] sw_data_r;
   reg sw_sof_n_r;
   reg sw_eof_n_r;
   reg sw_src_rdy_n_r;
   reg [`LB_HDR_CNT_W-1:0] emit_src;
   wire tx_dst_rdy_n;
   wire sw_out_free;
   wire sw_take;
   wire in_eof;

   assign sw_out_free = sw_src_rdy_n_r || !tx_dst_rdy_n;
   assign sw_in_ready = sw_state_r[0] || (sw_state_r[2] && sw_out_free);
   assign sw_take = loop_out_valid && sw_in_ready;
   assign in_eof = loop_out_data[`LB_BYTE_W];

   always @*
   begin
      emit_src = emit_r;
      if (hdr_len_r == `LB_HDR_LEN)
      begin
         if (emit_r < `LB_ADDR_LEN)
            emit_src = emit_r + ADDR_LEN_C;
         else
            emit_src = emit_r - ADDR_LEN_C;
      end
   end

   always @(posedge sys_clk_in)
   begin
      if (clk_en_in && sw_state_r[0] && sw_take)
         hdr_r[hdr_cnt_r] <= loop_out_data[`LB_BYTE_W-1:0];
   end

   always @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         sw_state_r <= S_COLL;
         hdr_cnt_r <= {`LB_HDR_CNT_W{1'b0}};
         hdr_len_r <= {`LB_HDR_CNT_W{1'b0}};
         emit_r <= {`LB_HDR_CNT_W{1'b0}};
         hdr_eof_r <= 1'b0;
         sw_data_r <= 8'h00;
         sw_sof_n_r <= 1'b1;
         sw_eof_n_r <= 1'b1;
         sw_src_rdy_n_r <= 1'b1;
      end
      else if (clk_en_in)
      begin
         if (sw_out_free)
            sw_src_rdy_n_r <= 1'b1;
         case (sw_state_r)
            S_COLL:
            begin
               if (sw_take)
               begin
                  hdr_cnt_r <= hdr_cnt_r + 1'b1;
                  if (in_eof || (hdr_cnt_r == `LB_HDR_LEN - 1))
                  begin
                     hdr_len_r <= hdr_cnt_r + 1'b1;
                     hdr_eof_r <= in_eof;
                     emit_r <= {`LB_HDR_CNT_W{1'b0}};
                     sw_state_r <= S_EMIT;
                  end
               end
            end
            S_EMIT:
            begin
               if (sw_out_free)
               begin
                  sw_data_r <= hdr_r[emit_src];
                  sw_sof_n_r <= (emit_r != 0);
                  sw_eof_n_r <= !(hdr_eof_r && (emit_r == hdr_len_r - 1'b1));
                  sw_src_rdy_n_r <= 1'b0;
                  emit_r <= emit_r + 1'b1;
                  if (emit_r == hdr_len_r - 1'b1)
                  begin
                     hdr_cnt_r <= {`LB_HDR_CNT_W{1'b0}};
                     sw_state_r <= hdr_eof_r ? S_COLL : S_PASS;
                  end
               end
            end
            S_PASS:
            begin
               if (sw_take)
               begin
                  sw_data_r <= loop_out_data[`LB_BYTE_W-1:0];
                  sw_sof_n_r <= 1'b1;
                  sw_eof_n_r <= !in_eof;
                  sw_src_rdy_n_r <= 1'b0;
                  if (in_eof)
                     sw_state_r <= S_COLL;
               end
            end
            default:
               sw_state_r <= S_COLL;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Transmit buffer: write side
   // ----------------------------------------------------------------------
   reg [7:0] tx_mem [0:DEPTH-1];
   reg tx_eof_mem [0:DEPTH-1];
   reg [ADDR_W-1:0] tx_wr_r;
   reg [ADDR_W-1:0] tx_wstart_r;
   reg [ADDR_W-1:0] tx_commit_r;
   reg [ADDR_W-1:0] tx_rd_r;
   reg [ADDR_W-1:0] tx_rstart_r;
   reg tx_drop_r;
   reg tx_cur_eof_r;
   reg [3:0] tx_state_r;
   wire tx_full;
   wire tx_no_frame;
   wire tx_take;
   wire tx_stuck;
   wire [ADDR_W-1:0] tx_fill;
   wire [ADDR_W-1:0] tx_rd_next;

   assign tx_full = ((tx_wr_r + 1'b1) == tx_rstart_r);
   assign tx_no_frame = (tx_commit_r == tx_rstart_r);
   assign tx_stuck = tx_full && tx_no_frame;
   assign tx_dst_rdy_n = tx_full && !tx_no_frame && !tx_drop_r;
   assign tx_take = !sw_src_rdy_n_r && !tx_dst_rdy_n;
   assign tx_fill = tx_wr_r - tx_rstart_r;
   assign tx_fifo_status_out = tx_fill[ADDR_W-1:`LB_STATUS_SHIFT];
   assign tx_rd_next = tx_rd_r + 1'b1;

   always @(posedge sys_clk_in)
   begin
      if (clk_en_in && tx_take && !tx_drop_r && !tx_stuck)
      begin
         tx_mem[tx_wr_r] <= sw_data_r;
         tx_eof_mem[tx_wr_r] <= !sw_eof_n_r;
      end
   end

   always @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         tx_wr_r <= {ADDR_W{1'b0}};
         tx_wstart_r <= {ADDR_W{1'b0}};
         tx_commit_r <= {ADDR_W{1'b0}};
         tx_drop_r <= 1'b0;
         tx_overflow_out <= 1'b0;
      end
      else if (clk_en_in)
      begin
         tx_overflow_out <= 1'b0;
         if (tx_take)
         begin
            if (tx_drop_r || tx_stuck)
            begin
               tx_drop_r <= !sw_eof_n_r ? 1'b0 : 1'b1;
               tx_overflow_out <= !tx_drop_r;
               if (!sw_eof_n_r)
                  tx_wr_r <= tx_wstart_r;
            end
            else
            begin
               tx_wr_r <= tx_wr_r + 1'b1;
               if (!sw_eof_n_r)
               begin
                  tx_commit_r <= tx_wr_r + 1'b1;
                  tx_wstart_r <= tx_wr_r + 1'b1;
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Transmit buffer: MAC side
   // ----------------------------------------------------------------------
   always @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         tx_state_r <= T_IDLE;
         tx_rd_r <= {ADDR_W{1'b0}};
         tx_rstart_r <= {ADDR_W{1'b0}};
         tx_cur_eof_r <= 1'b0;
         tx_data_out <= 8'h00;
         tx_data_valid_out <= 1'b0;
      end
      else if (clk_en_in)
      begin
         case (tx_state_r)
            T_IDLE:
            begin
               if (!tx_no_frame)
               begin
                  tx_rd_r <= tx_rstart_r;
                  tx_data_out <= tx_mem[tx_rstart_r];
                  tx_cur_eof_r <= tx_eof_mem[tx_rstart_r];
                  tx_data_valid_out <= 1'b1;
                  tx_state_r <= T_WAIT;
               end
            end
            T_WAIT, T_SEND:
            begin
               if (tx_retransmit_in)
               begin
                  tx_data_valid_out <= 1'b0;
                  tx_rd_r <= tx_rstart_r;
                  tx_state_r <= T_IDLE;
               end
               else if (tx_collision_in)
               begin
                  tx_data_valid_out <= 1'b0;
                  tx_state_r <= T_SKIP;
               end
               else if (tx_state_r[2] || tx_ack_in)
               begin
                  tx_rd_r <= tx_rd_next;
                  if (tx_cur_eof_r)
                  begin
                     tx_data_valid_out <= 1'b0;
                     tx_rstart_r <= tx_rd_next;
                     tx_state_r <= T_IDLE;
                  end
                  else
                  begin
                     tx_data_out <= tx_mem[tx_rd_next];
                     tx_cur_eof_r <= tx_eof_mem[tx_rd_next];
                     tx_state_r <= T_SEND;
                  end
               end
            end
            T_SKIP:
            begin
               tx_rd_r <= tx_rd_next;
               tx_cur_eof_r <= tx_eof_mem[tx_rd_next];
               if (tx_cur_eof_r)
               begin
                  tx_rstart_r <= tx_rd_next;
                  tx_state_r <= T_IDLE;
               end
            end
            default:
               tx_state_r <= T_IDLE;
         endcase
      end
   end
endmodule

// ### design/loopback_consts.vh
`ifndef LOOPBACK_CONSTS_VH
`define LOOPBACK_CONSTS_VH

// ----------------------------------------------------------------------
// Frame buffer geometry
// ----------------------------------------------------------------------
`define LB_BUF_ADDR_W 12
`define LB_STATUS_W 4
`define LB_STATUS_SHIFT 8
`define LB_BYTE_W 8

// ----------------------------------------------------------------------
// Loop FIFO between receive buffer and address swap
// ----------------------------------------------------------------------
`define LB_LOOP_DEPTH 16
`define LB_LOOP_AW 4
`define LB_LOOP_W 10

// ----------------------------------------------------------------------
// Address swap header layout
// ----------------------------------------------------------------------
`define LB_ADDR_LEN 6
`define LB_HDR_LEN 12
`define LB_HDR_CNT_W 4

`endif
